// ==== pcit_pkg.sv ====
package pcit_pkg;

   // ----------------------------------------------------------------
   // register indices reached over the i2c link
   // ----------------------------------------------------------------
   localparam logic [7:0] REG_CTRL = 8'h00;
   localparam logic [7:0] REG_IMASK = 8'h01;
   localparam logic [7:0] REG_FLAGS = 8'h02;
   localparam logic [7:0] REG_STATUS = 8'h03;

   // ----------------------------------------------------------------
   // field positions
   // ----------------------------------------------------------------
   localparam int CTRL_GMASK = 0;
   localparam int CTRL_AUDIO = 1;
   localparam int CTRL_ROLE = 2;
   localparam int CTRL_CUR = 4;
   localparam int STS_VBUS = 0;
   localparam int STS_ROLE = 1;
   localparam int STS_ADDR = 3;
   localparam int STS_GPIO = 4;
   localparam int FLAG_VBUS = 0;

   // ----------------------------------------------------------------
   // reset values and encodings
   // ----------------------------------------------------------------
   // global mask set, audio accessory on, default current, role from strap
   localparam logic [7:0] CTRL_RESET = 8'h13;
   localparam logic [7:0] IMASK_RESET = 8'h00;
   localparam logic [7:0] FLAGS_RESET = 8'h00;
   localparam logic [1:0] CUR_DEFAULT = 2'h1;
   localparam logic [1:0] CUR_1A5 = 2'h2;
   localparam logic [1:0] CUR_3A = 2'h3;
   localparam logic [1:0] ADDR_TOP = 2'h1;
   localparam logic [3:0] ADDR_LOW = 4'h1;

   // ----------------------------------------------------------------
   // timing
   // ----------------------------------------------------------------
   localparam int CLK_KHZ = 25000;
   localparam int VBUS_RISE_US = 250;
   localparam int VBUS_FALL_MS = 10;
   // least times, rounded up to whole cycles
   localparam int VBUS_RISE_CYC = (VBUS_RISE_US * CLK_KHZ + 999) / 1000;
   localparam int VBUS_FALL_CYC = VBUS_FALL_MS * CLK_KHZ;
   localparam logic [1:0] STRAP_WAIT = 2'h3;

   // ----------------------------------------------------------------
   // link states
   // ----------------------------------------------------------------
   typedef enum logic [3:0] {
      LNK_IDLE,
      LNK_ADDR,
      LNK_AACK,
      LNK_IDX,
      LNK_IACK,
      LNK_WR,
      LNK_WACK,
      LNK_RD,
      LNK_RACK
   } pcit_lnk_st_t;

endpackage : pcit_pkg

// ==== pcit_sync.sv ====
`timescale 1ns/1ps
module pcit_sync #(
   parameter int W = 1
) (
   // clock
   input wire logic clk,
   // level in and out
   input wire logic [W-1:0] d,
   output logic [W-1:0] q
);
   logic [W-1:0] meta;

   // two-flop synchroniser; meta is read only by q
   always_ff @(posedge clk)
   begin
      meta <= d;
      q <= meta;
   end

endmodule : pcit_sync

// ==== pcit_debounce.sv ====
`timescale 1ns/1ps
module pcit_debounce #(
   parameter int RISE_CYC = pcit_pkg::VBUS_RISE_CYC,
   parameter int FALL_CYC = pcit_pkg::VBUS_FALL_CYC
) (
   // clock and reset
   input wire logic clk,
   input wire logic sys_rst,
   // synchronised level and filtered result
   input wire logic level_in,
   output logic valid,
   output logic changed
);
   localparam logic [17:0] RISE_LAST = 18'(RISE_CYC - 1);
   localparam logic [17:0] FALL_LAST = 18'(FALL_CYC - 1);
   logic [17:0] cnt;

   // any glitch back to the held level restarts the wait
   always_ff @(posedge clk)
   begin
      if (sys_rst)
      begin
         cnt <= 18'h0;
         valid <= 1'b0;
         changed <= 1'b0;
      end
      else if (level_in == valid)
      begin
         cnt <= 18'h0;
         changed <= 1'b0;
      end
      else if (cnt == (valid ? FALL_LAST : RISE_LAST))
      begin
         valid <= level_in;
         cnt <= 18'h0;
         changed <= 1'b1;
      end
      else
      begin
         cnt <= cnt + 18'h1;
         changed <= 1'b0;
      end
   end

endmodule : pcit_debounce

// ==== pcit_top.sv ====
// Contract
// - After reset the port role comes from the role strap, audio support is on, all interrupts masked.
// - The interrupt pin is active low, open drain, and pulls only for a pending event.
// - After reset the interrupt pin floats and the global mask is set; clearing it alone pulls nothing.
// - An unmasked event pulls the pin low until the host writes a one to that flag.
// - While the global mask is set the pin floats whatever events occur.
// - Events during the global mask are kept and pull the pin once the mask clears.
// - A flag holds until a one is written to its position or reset is applied, the only ways to clear it.
// - Outside gpio mode the target address is 0,1,A,0,0,0,1 then read/write, A latched once from the address pin after reset; in gpio mode it answers no address.
// - A read with no index first starts at the currently selected register.
// - The target follows the i2c bus protocol at fast-mode speed.
// - Source current codes are 01 default, 10 1.5 A, 11 3 A, taken from pins in gpio mode.
// - Vbus valid rises only after the sense input has stayed high 250 to 500 us.
// - Vbus valid falls only after the sense input has stayed low 10 to 20 ms.
`timescale 1ns/1ps
module pcit_top #(
   parameter int VBUS_RISE_CYC = pcit_pkg::VBUS_RISE_CYC,
   parameter int VBUS_FALL_CYC = pcit_pkg::VBUS_FALL_CYC
) (
   // system clock and reset
   input wire logic clk,
   input wire logic sys_rst,
   // i2c link, scl is the link clock
   input wire logic scl_in,
   input wire logic sda_in,
   output logic sda_out,
   output logic sda_oe,
   // straps and mode pins
   input wire logic addr_select_pin,
   input wire logic [1:0] role_strap,
   input wire logic gpio_mode,
   input wire logic gpio_cur_hi,
   input wire logic gpio_cur_lo,
   // interrupt pin, open drain
   output logic irq_out_low,
   output logic irq_oe,
   // vbus sense
   input wire logic vbus_sense_in,
   output logic vbus_valid,
   // events from the attach logic
   input wire logic [6:0] event_in,
   // configuration seen by the rest of the chip
   output logic [1:0] port_role,
   output logic audio_acc_en,
   output logic source_current_sel_hi,
   output logic source_current_sel_lo
);

   // ----------------------------------------------------------------
   // declarations
   // ----------------------------------------------------------------
   logic [6:0] pins_s;
   logic vbus_s;
   logic addr_s;
   logic [1:0] role_s;
   logic gpio_s;
   logic [1:0] gcur_s;
   logic [1:0] strap_cnt;
   logic strap_done;
   logic addr_strap;
   logic vbus_chg;
   logic [7:0] ctrl;
   logic [7:0] imask;
   logic [7:0] flags;
   logic [7:0] rd_word;
   logic wr_tog_s;
   logic wr_tog_d;
   logic rd_tog_s;
   logic rd_tog_d;
   logic wr_pulse;
   logic rd_pulse;
   logic [7:0] flag_clr;
   logic [7:0] flag_set;
   // link domain
   pcit_pkg::pcit_lnk_st_t st;
   logic start_tog;
   logic start_seen;
   logic [2:0] bitcnt;
   logic [6:0] shreg;
   logic [7:0] rx_byte;
   logic rw;
   logic [7:0] ptr;
   logic [7:0] wr_idx;
   logic [7:0] wr_data;
   logic wr_tog;
   logic [7:0] rd_idx;
   logic rd_tog;
   logic sda_drv;
   logic [1:0] lnk_cfg;

   // ----------------------------------------------------------------
   // helpers
   // ----------------------------------------------------------------
   function automatic logic [7:0] reg_read(input logic [7:0] idx, input logic [7:0] c,
                                           input logic [7:0] m, input logic [7:0] f,
                                           input logic [7:0] s);
      logic [7:0] r;
      r = 8'h0;
      case (idx)
         pcit_pkg::REG_CTRL: r = c;
         pcit_pkg::REG_IMASK: r = m;
         pcit_pkg::REG_FLAGS: r = f;
         pcit_pkg::REG_STATUS: r = s;
         default: r = 8'h0;
      endcase
      return r;
   endfunction : reg_read

   function automatic logic [7:0] status_word(input logic v, input logic [1:0] role,
                                              input logic a, input logic g);
      logic [7:0] s;
      s = 8'h0;
      s[pcit_pkg::STS_VBUS] = v;
      s[pcit_pkg::STS_ROLE +: 2] = role;
      s[pcit_pkg::STS_ADDR] = a;
      s[pcit_pkg::STS_GPIO] = g;
      return s;
   endfunction : status_word

   // ----------------------------------------------------------------
   // pin and crossing synchronisers
   // ----------------------------------------------------------------
   pcit_sync #(.W(7)) u_pin_sync (
      .clk(clk),
      .d({vbus_sense_in, addr_select_pin, role_strap, gpio_mode, gpio_cur_hi, gpio_cur_lo}),
      .q(pins_s)
   );
   assign vbus_s = pins_s[6];
   assign addr_s = pins_s[5];
   assign role_s = pins_s[4:3];
   assign gpio_s = pins_s[2];
   assign gcur_s = pins_s[1:0];

   pcit_sync #(.W(2)) u_tog_sync (
      .clk(clk),
      .d({wr_tog, rd_tog}),
      .q({wr_tog_s, rd_tog_s})
   );

   // static configuration into the link domain
   pcit_sync #(.W(2)) u_cfg_sync (
      .clk(scl_in),
      .d({gpio_s, addr_strap}),
      .q(lnk_cfg)
   );

   // ----------------------------------------------------------------
   // vbus debounce
   // ----------------------------------------------------------------
   pcit_debounce #(
      .RISE_CYC(VBUS_RISE_CYC),
      .FALL_CYC(VBUS_FALL_CYC)
   ) u_vbus_deb (
      .clk(clk),
      .sys_rst(sys_rst),
      .level_in(vbus_s),
      .valid(vbus_valid),
      .changed(vbus_chg)
   );

   // ----------------------------------------------------------------
   // strap capture after reset release
   // ----------------------------------------------------------------
   // wait until the synchroniser carries real pin levels
   always_ff @(posedge clk)
   begin
      if (sys_rst)
      begin
         strap_cnt <= 2'h0;
         strap_done <= 1'b0;
         addr_strap <= 1'b0;
      end
      else if (!strap_done)
      begin
         strap_cnt <= strap_cnt + 2'h1;
         if (strap_cnt == pcit_pkg::STRAP_WAIT)
         begin
            strap_done <= 1'b1;
            addr_strap <= addr_s;
         end
      end
   end

   // ----------------------------------------------------------------
   // host writes and reads arriving from the link
   // ----------------------------------------------------------------
   always_ff @(posedge clk)
   begin
      if (sys_rst)
      begin
         wr_tog_d <= 1'b0;
         rd_tog_d <= 1'b0;
      end
      else
      begin
         wr_tog_d <= wr_tog_s;
         rd_tog_d <= rd_tog_s;
      end
   end
   assign wr_pulse = wr_tog_s ^ wr_tog_d;
   assign rd_pulse = rd_tog_s ^ rd_tog_d;

   // control register; the strap load happens once, later writes win
   always_ff @(posedge clk)
   begin
      if (sys_rst)
      begin
         ctrl <= pcit_pkg::CTRL_RESET;
      end
      else if (!strap_done && strap_cnt == pcit_pkg::STRAP_WAIT)
      begin
         ctrl[pcit_pkg::CTRL_ROLE +: 2] <= role_s;
      end
      else if (wr_pulse && wr_idx == pcit_pkg::REG_CTRL)
      begin
         ctrl <= wr_data;
      end
   end

   // individual masks
   always_ff @(posedge clk)
   begin
      if (sys_rst)
      begin
         imask <= pcit_pkg::IMASK_RESET;
      end
      else if (wr_pulse && wr_idx == pcit_pkg::REG_IMASK)
      begin
         imask <= wr_data;
      end
   end

   // ----------------------------------------------------------------
   // interrupt flags
   // ----------------------------------------------------------------
   assign flag_set = {event_in, vbus_chg};
   assign flag_clr = (wr_pulse && wr_idx == pcit_pkg::REG_FLAGS) ? wr_data : 8'h0;

   // write one to clear, a new event beats the clear
   // events are kept while the global mask is set
   always_ff @(posedge clk)
   begin
      if (sys_rst)
      begin
         flags <= pcit_pkg::FLAGS_RESET;
      end
      else
      begin
         flags <= (flags & ~flag_clr) | flag_set;
      end
   end

   // released by reset and by the global mask
   always_ff @(posedge clk)
   begin
      if (sys_rst)
      begin
         irq_oe <= 1'b0;
      end
      else
      begin
         irq_oe <= !ctrl[pcit_pkg::CTRL_GMASK] && |(flags & ~imask);
      end
   end
   assign irq_out_low = 1'b0;

   // read data is reloaded only on request, so it stands still while shifted out
   always_ff @(posedge clk)
   begin
      if (sys_rst)
      begin
         rd_word <= 8'h0;
      end
      else if (rd_pulse)
      begin
         rd_word <= reg_read(rd_idx, ctrl, imask, flags,
                             status_word(vbus_valid, ctrl[pcit_pkg::CTRL_ROLE +: 2],
                                         addr_strap, gpio_s));
      end
   end

   // ----------------------------------------------------------------
   // configuration outputs
   // ----------------------------------------------------------------
   // current code from pins in gpio mode, else from the register
   always_ff @(posedge clk)
   begin
      if (sys_rst)
      begin
         source_current_sel_hi <= pcit_pkg::CUR_DEFAULT[1];
         source_current_sel_lo <= pcit_pkg::CUR_DEFAULT[0];
         port_role <= 2'h0;
         audio_acc_en <= 1'b1;
      end
      else
      begin
         source_current_sel_hi <= gpio_s ? gcur_s[1] : ctrl[pcit_pkg::CTRL_CUR + 1];
         source_current_sel_lo <= gpio_s ? gcur_s[0] : ctrl[pcit_pkg::CTRL_CUR];
         port_role <= ctrl[pcit_pkg::CTRL_ROLE +: 2];
         audio_acc_en <= ctrl[pcit_pkg::CTRL_AUDIO];
      end
   end

   // ----------------------------------------------------------------
   // link: start detection
   // ----------------------------------------------------------------
   // sda falling while scl high marks a start; stop needs no action
   // because every transfer of ours begins with a fresh start
   always_ff @(negedge sda_in or posedge sys_rst)
   begin
      if (sys_rst)
      begin
         start_tog <= 1'b0;
      end
      else if (scl_in)
      begin
         start_tog <= ~start_tog;
      end
   end

   // ----------------------------------------------------------------
   // link: bit sampling on the rising scl edge
   // ----------------------------------------------------------------
   assign rx_byte = {shreg, sda_in};

   // byte framing with ninth bit acknowledge
   always_ff @(posedge scl_in or posedge sys_rst)
   begin
      if (sys_rst)
      begin
         st <= pcit_pkg::LNK_IDLE;
         start_seen <= 1'b0;
         bitcnt <= 3'h0;
         shreg <= 7'h0;
         rw <= 1'b0;
         ptr <= 8'h0;
         wr_idx <= 8'h0;
         wr_data <= 8'h0;
         wr_tog <= 1'b0;
         rd_idx <= 8'h0;
         rd_tog <= 1'b0;
      end
      else if (start_tog != start_seen)
      begin
         start_seen <= start_tog;
         st <= pcit_pkg::LNK_ADDR;
         bitcnt <= 3'h1;
         shreg <= {6'h0, sda_in};
      end
      else
      begin
         case (st)
            pcit_pkg::LNK_ADDR:
            begin
               shreg <= rx_byte[6:0];
               bitcnt <= bitcnt + 3'h1;
               // address with the strapped bit five
               if (bitcnt == 3'h7 && !lnk_cfg[1] &&
                   rx_byte[7:1] == {pcit_pkg::ADDR_TOP, lnk_cfg[0], pcit_pkg::ADDR_LOW})
               begin
                  rw <= sda_in;
                  st <= pcit_pkg::LNK_AACK;
                  if (sda_in)
                  begin
                     // read starts at the current index
                     rd_idx <= ptr;
                     rd_tog <= ~rd_tog;
                  end
               end
               else if (bitcnt == 3'h7)
               begin
                  st <= pcit_pkg::LNK_IDLE;
               end
            end
            pcit_pkg::LNK_AACK:
            begin
               bitcnt <= 3'h0;
               st <= rw ? pcit_pkg::LNK_RD : pcit_pkg::LNK_IDX;
            end
            pcit_pkg::LNK_IDX:
            begin
               shreg <= rx_byte[6:0];
               bitcnt <= bitcnt + 3'h1;
               if (bitcnt == 3'h7)
               begin
                  ptr <= rx_byte;
                  st <= pcit_pkg::LNK_IACK;
               end
            end
            pcit_pkg::LNK_IACK, pcit_pkg::LNK_WACK:
            begin
               bitcnt <= 3'h0;
               st <= pcit_pkg::LNK_WR;
            end
            pcit_pkg::LNK_WR:
            begin
               shreg <= rx_byte[6:0];
               bitcnt <= bitcnt + 3'h1;
               if (bitcnt == 3'h7)
               begin
                  wr_idx <= ptr;
                  wr_data <= rx_byte;
                  wr_tog <= ~wr_tog;
                  ptr <= ptr + 8'h1;
                  st <= pcit_pkg::LNK_WACK;
               end
            end
            pcit_pkg::LNK_RD:
            begin
               bitcnt <= bitcnt + 3'h1;
               if (bitcnt == 3'h7)
               begin
                  ptr <= ptr + 8'h1;
                  st <= pcit_pkg::LNK_RACK;
               end
            end
            pcit_pkg::LNK_RACK:
            begin
               bitcnt <= 3'h0;
               // host ack asks for the next byte, nack ends the read
               if (!sda_in)
               begin
                  rd_idx <= ptr;
                  rd_tog <= ~rd_tog;
                  st <= pcit_pkg::LNK_RD;
               end
               else
               begin
                  st <= pcit_pkg::LNK_IDLE;
               end
            end
            default:
            begin
               st <= pcit_pkg::LNK_IDLE;
            end
         endcase
      end
   end

   // ----------------------------------------------------------------
   // link: drive on the falling scl edge
   // ----------------------------------------------------------------
   // rd_word must be stable half an scl period after the request;
   // at fast-mode rate that leaves some thirty system clocks
   always_ff @(negedge scl_in or posedge sys_rst)
   begin
      if (sys_rst)
      begin
         sda_drv <= 1'b0;
      end
      else
      begin
         case (st)
            pcit_pkg::LNK_AACK, pcit_pkg::LNK_IACK, pcit_pkg::LNK_WACK: sda_drv <= 1'b1;
            pcit_pkg::LNK_RD: sda_drv <= ~rd_word[3'h7 - bitcnt];
            default: sda_drv <= 1'b0;
         endcase
      end
   end
   assign sda_oe = sda_drv;
   assign sda_out = 1'b0;

endmodule : pcit_top

// ==== pcit_checker.sv ====
`timescale 1ns/1ps
module pcit_checker #(
   parameter int VBUS_RISE_CYC = 8,
   parameter int VBUS_FALL_CYC = 16
) (
   // clock and reset
   input wire logic clk,
   input wire logic sys_rst,
   // open drain pins
   input wire logic sda_out,
   input wire logic sda_oe,
   input wire logic irq_out_low,
   input wire logic irq_oe,
   // vbus, events and config
   input wire logic vbus_sense_in,
   input wire logic vbus_valid,
   input wire logic [6:0] event_in,
   input wire logic audio_acc_en,
   input wire logic source_current_sel_hi,
   input wire logic source_current_sel_lo
);
   default clocking @(posedge clk); endclocking
   default disable iff (sys_rst);
   // wide enough for the full fall time at the real clock rate
   logic [17:0] hi_run;
   logic [17:0] lo_run;
   logic [7:0] since_ack;
   logic [7:0] since_cause;

   // ----------------------------------------
   // helper counters and assertions
   // ----------------------------------------
   // raw sense run lengths; saturate so a long run never wraps to a short one
   always_ff @(posedge clk)
   begin
      hi_run <= (sys_rst || !vbus_sense_in) ? 18'h00000 : hi_run + {17'h00000, ~&hi_run};
      lo_run <= (sys_rst || vbus_sense_in) ? 18'h00000 : lo_run + {17'h00000, ~&lo_run};
   end

   // cycles since an acknowledge, and since anything that may raise the pin
   always_ff @(posedge clk)
   begin
      if (sys_rst)
      begin
         since_ack <= 8'hff;
         since_cause <= 8'hff;
      end
      else
      begin
         since_ack <= sda_oe ? 8'h00 : since_ack + {7'h00, ~&since_ack};
         since_cause <= (sda_oe || |event_in || $changed(vbus_valid)) ? 8'h00 :
                        since_cause + {7'h00, ~&since_cause};
      end
   end

   chk_irq_pin_low: assert property (irq_out_low == 1'b0)
      else $error("interrupt pin driven high");
   chk_sda_pin_low: assert property (sda_out == 1'b0)
      else $error("data pin driven high");
   chk_reset_state: assert property ($fell(sys_rst) |-> !irq_oe && !vbus_valid && audio_acc_en
      && {source_current_sel_hi, source_current_sel_lo} == 2'h1)
      else $error("wrong state after reset");
   chk_vbus_rise_min: assert property ($rose(vbus_valid) |-> hi_run >= VBUS_RISE_CYC)
      else $error("vbus valid rose too early");
   chk_vbus_rise_max: assert property (hi_run == 2 * VBUS_RISE_CYC |-> vbus_valid)
      else $error("vbus valid rose too late");
   chk_vbus_fall_min: assert property ($fell(vbus_valid) |-> lo_run >= VBUS_FALL_CYC)
      else $error("vbus valid fell too early");
   chk_irq_fall_cause: assert property ($fell(irq_oe) |-> since_ack < 8'h40)
      else $error("interrupt released without a host write");
   chk_irq_rise_cause: assert property ($rose(irq_oe) |-> since_cause < 8'h40)
      else $error("interrupt pulled without a cause");

   cov_irq_clear: cover property ($fell(irq_oe));
   cov_vbus_up: cover property ($rose(vbus_valid));
   cov_vbus_down: cover property ($fell(vbus_valid));
endmodule : pcit_checker

bind pcit_top pcit_checker #(
   .VBUS_RISE_CYC(VBUS_RISE_CYC),
   .VBUS_FALL_CYC(VBUS_FALL_CYC)
) u_chk (.clk, .sys_rst, .sda_out, .sda_oe, .irq_out_low, .irq_oe, .vbus_sense_in,
   .vbus_valid, .event_in, .audio_acc_en, .source_current_sel_hi, .source_current_sel_lo);

// ==== pcit_host_model.sv ====
`timescale 1ns/1ps
module pcit_host_model (
   // link pins; the host only ever pulls data low
   output logic scl,
   output logic sda_pull,
   input wire logic sda
);
   // ----------------------------------------
   // bus host
   // ----------------------------------------
   // clock stands high and data released between frames
   initial
   begin
      scl = 1'b1;
      sda_pull = 1'b0;
   end

   // data set while clock low, sampled at the rising edge
   task automatic bit_io(input logic b, input int hold, output logic r);
      #5 sda_pull = ~b;
      #10 scl = 1'b1;
      r = sda;
      #(15 + hold) scl = 1'b0;
   endtask : bit_io

   // start, also a repeated start; odd delay keeps the phase unrelated
   task automatic start();
      #7 sda_pull = 1'b0;
      #10 scl = 1'b1;
      #15 sda_pull = 1'b1;
      #15 scl = 1'b0;
   endtask : start

   task automatic stop();
      #5 sda_pull = 1'b1;
      #10 scl = 1'b1;
      #15 sda_pull = 1'b0;
   endtask : stop

   // msb first; the long ninth bit leaves the target time to answer
   task automatic send(input logic [7:0] d, output logic ack);
      logic r;
      for (int i = 7; i >= 0; i--)
         bit_io(d[i], 0, r);
      bit_io(1'b1, 300, r);
      ack = ~r;
   endtask : send

   task automatic recv(input logic more, output logic [7:0] d);
      logic r;
      for (int i = 7; i >= 0; i--)
      begin
         bit_io(1'b1, 0, r);
         d[i] = r;
      end
      bit_io(~more, 300, r);
   endtask : recv
endmodule : pcit_host_model

// ==== port_ctrl_i2c_irq_target_tb_top.sv ====
`timescale 1ns/1ps
module port_ctrl_i2c_irq_target_tb_top;
   logic clk, sys_rst, scl, sda_pull, sda_oe, addr_select_pin, gpio_mode;
   logic gpio_cur_hi, gpio_cur_lo, irq_oe, vbus_sense_in, vbus_valid, audio_acc_en;
   logic source_current_sel_hi, source_current_sel_lo, ack;
   logic [1:0] role_strap, port_role;
   logic [6:0] event_in;
   logic [7:0] seen, rd_d, fl;
   logic [7:0] exp_q[$];
   int err_total, checked;
   event seen_ev;
   // pull-up on the data line
   wire sda = ~(sda_pull | sda_oe);

   pcit_host_model u_host (.scl, .sda_pull, .sda);
   pcit_top #(.VBUS_RISE_CYC(8), .VBUS_FALL_CYC(16)) u_dut (.clk, .sys_rst, .scl_in(scl),
      .sda_in(sda), .sda_out(), .sda_oe, .addr_select_pin, .role_strap, .gpio_mode,
      .gpio_cur_hi, .gpio_cur_lo, .irq_out_low(), .irq_oe, .vbus_sense_in, .vbus_valid,
      .event_in, .port_role, .audio_acc_en, .source_current_sel_hi, .source_current_sel_lo);

   // ----------------------------------------
   // checking
   // ----------------------------------------
   task automatic check(input logic [7:0] v, input logic [7:0] e);
      checked++;
      if (v !== e)
      begin
         err_total++;
         $display("mismatch at %0t: seen %h expected %h", $time, v, e);
      end
   endtask : check

   // note the expectation, then hand the observed value to the monitor
   task automatic obs(input logic [7:0] v, input logic [7:0] e);
      exp_q.push_back(e);
      seen = v;
      ->seen_ev;
      #1;
   endtask : obs

   always @(seen_ev) check(seen, exp_q.pop_front());

   task automatic summarize();
      if (err_total == 0 && checked > 0)
         $display("All checks passed");
      else
         $display("Checks failed");
      $finish;
   endtask : summarize

   // ----------------------------------------
   // stimulus
   // ----------------------------------------
   task automatic wr(input logic [7:0] idx, input logic [7:0] d, input logic with_d);
      u_host.start();
      u_host.send({2'h1, addr_select_pin, 4'h1, 1'b0}, ack);
      u_host.send(idx, ack);
      if (with_d)
         u_host.send(d, ack);
      u_host.stop();
      repeat (6) @(negedge clk);
   endtask : wr

   // index alone, then a read that names no index
   task automatic rd_chk(input logic [7:0] idx, input logic [7:0] e);
      wr(idx, 8'h00, 1'b0);
      u_host.start();
      u_host.send({2'h1, addr_select_pin, 4'h1, 1'b1}, ack);
      u_host.recv(1'b0, rd_d);
      u_host.stop();
      obs(rd_d, e);
   endtask : rd_chk

   task automatic probe(input logic a, input logic [7:0] e);
      u_host.start();
      u_host.send({2'h1, a, 4'h1, 1'b0}, ack);
      u_host.stop();
      obs({7'h00, ack}, e);
   endtask : probe

   task automatic pulse(input logic [7:0] f);
      @(negedge clk);
      event_in = f[7:1];
      @(negedge clk);
      event_in = 7'h00;
      repeat (3) @(negedge clk);
   endtask : pulse

   task automatic vbus(input logic v, input int n);
      @(negedge clk);
      vbus_sense_in = v;
      repeat (n) @(negedge clk);
   endtask : vbus

   initial
   begin
      clk = 1'b0;
      forever #20 clk = ~clk;
   end

   // hang guard, well beyond the expected run
   initial
   begin
      #800000;
      err_total++;
      summarize();
   end

   initial
   begin
      void'($urandom(29162));
      sys_rst = 1'b1;
      addr_select_pin = 1'($urandom);
      role_strap = 2'($urandom_range(2));
      {gpio_mode, gpio_cur_hi, gpio_cur_lo, vbus_sense_in} = 4'h0;
      event_in = 7'h00;
      fl = 8'h02 << $urandom_range(6);
      repeat (2) @(negedge clk);
      sys_rst = 1'b0;
      repeat (12) @(negedge clk);
      obs({port_role, audio_acc_en, source_current_sel_hi, irq_oe}, {3'h0, role_strap, 3'h4});
      rd_chk(8'h00, {4'h1, role_strap, 2'h3});
      probe(~addr_select_pin, 8'h00);
      probe(addr_select_pin, 8'h01);
      for (int c = 1; c < 4; c++)
      begin
         wr(8'h00, {2'h0, 2'(c), role_strap, 2'h3}, 1'b1);
         obs({6'h00, source_current_sel_hi, source_current_sel_lo}, 8'(c));
      end
      gpio_mode = 1'b1;
      {gpio_cur_hi, gpio_cur_lo} = 2'($urandom_range(3, 1));
      repeat (4) @(negedge clk);
      obs({source_current_sel_hi, source_current_sel_lo}, {gpio_cur_hi, gpio_cur_lo});
      probe(addr_select_pin, 8'h00);
      @(negedge clk);
      gpio_mode = 1'b0;
      rd_chk(8'h03, {4'h0, addr_select_pin, role_strap, 1'b0});
      pulse(fl);
      obs(irq_oe, 8'h00);
      wr(8'h00, {4'h1, role_strap, 2'h2}, 1'b1);
      obs(irq_oe, 8'h01);
      rd_chk(8'h02, fl);
      wr(8'h02, ~fl, 1'b1);
      obs(irq_oe, 8'h01);
      wr(8'h02, fl, 1'b1);
      obs({irq_oe, ack}, 8'h01);
      wr(8'h01, fl, 1'b1);
      pulse(fl);
      obs(irq_oe, 8'h00);
      wr(8'h00, {4'h1, role_strap, 2'h3}, 1'b1);
      wr(8'h01, 8'h00, 1'b1);
      obs(irq_oe, 8'h00);
      wr(8'h00, {4'h1, role_strap, 2'h2}, 1'b1);
      obs(irq_oe, 8'h01);
      wr(8'h02, fl, 1'b1);
      vbus(1'b1, 5);
      vbus(1'b0, 3);
      obs({vbus_valid, irq_oe}, 8'h00);
      vbus(1'b1, 40);
      obs({vbus_valid, irq_oe}, 8'h03);
      rd_chk(8'h02, 8'h01);
      vbus(1'b0, 10);
      obs(vbus_valid, 8'h01);
      vbus(1'b0, 30);
      obs(vbus_valid, 8'h00);
      sys_rst = 1'b1;
      repeat (2) @(negedge clk);
      sys_rst = 1'b0;
      obs({irq_oe, vbus_valid}, 8'h00);
      summarize();
   end
endmodule : port_ctrl_i2c_irq_target_tb_top
